//--- verif/ebzat_core_properties.sv
`timescale 1ns/100ps
`default_nettype none
module ebzat_core_properties
  import ebzat_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire ebzat_pkg::ebzat_req_s i_req,
  input wire logic o_req_ready,
  input wire logic o_done,
  input wire ebzat_pkg::ebzat_pins_s o_pins
);
  import ebzat_pkg::*;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_take;
    i_req.valid && o_req_ready;
  endsequence
  a_take_busy: assert property (s_take |=> !o_req_ready)
    else $error("not busy after take");
  a_take_done: assert property (s_take |-> ##[1:80] o_done)
    else $error("access never ended");
  a_done_pulse: assert property (o_done |-> o_req_ready ##1 !o_done)
    else $error("done not single");
  a_one_zone: assert property ($onehot0(~o_pins.cs_n))
    else $error("two zones selected");
  a_strobe_excl: assert property (o_pins.rd_n || o_pins.we_n)
    else $error("both strobes low");
  a_strobe_in_cs: assert property (!(o_pins.rd_n && o_pins.we_n) |-> !(&o_pins.cs_n))
    else $error("strobe outside select");
  a_lead_first: assert property ($fell(&o_pins.cs_n) |-> o_pins.rd_n && o_pins.we_n)
    else $error("no lead cycle");
  a_write_dir: assert property (!o_pins.we_n |-> !o_pins.rnw)
    else $error("rnw high in write");
  a_read_dir: assert property (!o_pins.rd_n |-> o_pins.rnw)
    else $error("rnw low in read");
endmodule
bind ebzat_core ebzat_core_properties u_props (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_req(i_req),
  .o_req_ready(o_req_ready), .o_done(o_done), .o_pins(o_pins));
`default_nettype wire

//--- verif/ebzat_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module ebzat_mem_model
  import ebzat_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire ebzat_pkg::ebzat_pins_s i_pins,
  input wire logic i_slow,
  output logic o_ready
);
  import ebzat_pkg::*;
  logic [2:0] cnt;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt <= 3'h0;
    end else if (&i_pins.cs_n) begin
      cnt <= 3'h0;
    end else if (cnt != 3'h6) begin
      cnt <= cnt + 3'h1;
    end
  end
  // slow part holds off its first six selected cycles
  assign o_ready = !(i_slow && !(&i_pins.cs_n) && cnt != 3'h6);
endmodule
`default_nettype wire

//--- verif/tb_ext_bus_zone_access_timing.sv
`timescale 1ns/100ps
`default_nettype none
`include "ebzat_map.svh"
module tb_ext_bus_zone_access_timing;
  import ebzat_pkg::*;
  logic i_clk, i_rst_n, i_wr, i_rd, i_ext_ready, o_req_ready, o_done, slow;
  logic [3:0] i_addr;
  logic [15:0] i_wdata, o_rdata, rv;
  ebzat_req_s i_req;
  ebzat_pins_s o_pins;
  int fails, checked;
  // {slow, write, zone, config}
  logic [20:0] tab [8] = '{21'h010001, 21'h0a5700, 21'h034049, 21'h0f0b80,
    21'h148005, 21'h1d8300, 21'h160005, 21'h003fff};
  ebzat_core DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_req(i_req), .o_req_ready(o_req_ready), .o_done(o_done),
    .i_ext_ready(i_ext_ready), .o_pins(o_pins));
  ebzat_mem_model u_mem (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_pins(o_pins), .i_slow(slow),
    .o_ready(i_ext_ready));
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 rv = o_rdata;
  endtask
  task automatic acc(input logic [20:0] e);
    ebzat_cfg_s c;
    logic w, sb, seen;
    int l, a, t, n;
    int el, ea, et;
    c = e[15:0];
    w = e[19];
    l = 0;
    a = 0;
    t = 0;
    seen = 1'b0;
    el = w ? c.wr_lead : c.rd_lead;
    ea = w ? c.wr_active : c.rd_active;
    et = w ? c.wr_trail : c.rd_trail;
    if (c.double_t) begin
      el = el * 2;
      ea = ea * 2;
      et = et * 2;
    end
    @(posedge i_clk);
    slow <= e[20];
    i_req <= '{1'b1, w, e[18:16]};
    @(posedge i_clk);
    i_req.valid <= 1'b0;
    for (n = 0; n < 100 && !(seen && o_pins.cs_n[e[18:16]]); n++) begin
      @(posedge i_clk);
      #1 sb = w ? o_pins.we_n : o_pins.rd_n;
      if (!sb) begin
        a++;
        seen = 1'b1;
      end else if (!o_pins.cs_n[e[18:16]]) begin
        if (seen) t++;
        else l++;
      end
    end
    if (n == 100) begin
      fails++;
      report_and_stop();
    end
    chk("lead", 16'(l), 16'(el));
    chk("active", c.rdy_en ? 16'(a > ea + 1) : 16'(a), c.rdy_en ? 16'h1 : 16'(ea + 1));
    chk("trail", 16'(t), 16'(et));
  endtask
  initial begin
    i_rst_n = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 4'h0;
    i_wdata = 16'h0;
    i_req = '0;
    slow = 1'b0;
    fails = 0;
    checked = 0;
    repeat (5) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rd(4'h0);
    chk("cfg reset", rv, `EBZAT_CFG_RESET);
    wr(`EBZAT_REG_MODE, 16'h0020);
    rd(`EBZAT_REG_MODE);
    chk("mode", rv, 16'h0020);
    wr(4'hc, 16'hffff);
    rd(4'hc);
    chk("unmapped", rv, 16'h0000);
    for (int k = 0; k < 7; k++) wr({1'b0, tab[k][18:16]}, tab[k][15:0]);
    for (int k = 0; k < 8; k++) begin
      rd({1'b0, tab[k][18:16]});
      chk("cfg", rv, tab[k][15:0]);
    end
    $display("register test done");
    for (int k = 0; k < 8; k++) begin
      acc(tab[k]);
      if (k == 6) begin
        rd(`EBZAT_REG_STATUS);
        chk("status", rv, 16'h0600);
      end
    end
    $display("access test done");
    report_and_stop();
  end
  initial begin
    repeat (5000) @(posedge i_clk);
    fails++;
    report_and_stop();
  end
endmodule
`default_nettype wire

//--- verilog/ebzat_core.sv
`timescale 1ns/100ps
`default_nettype none
`include "ebzat_map.svh"
module ebzat_core
  import ebzat_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [`EBZAT_ADDR_W-1:0] i_addr,
  input wire logic [`EBZAT_DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [`EBZAT_DATA_W-1:0] o_rdata,
  input wire ebzat_pkg::ebzat_req_s i_req,
  output logic o_req_ready,
  output logic o_done,
  input wire logic i_ext_ready,
  output ebzat_pkg::ebzat_pins_s o_pins
);
  import ebzat_pkg::*;

  ebzat_cfg_s cfg [`EBZAT_ZONES];
  logic [`EBZAT_ZONES-1:0] ready_mode;
  ebzat_phase_e phase;
  logic [`EBZAT_CNT_W-1:0] cnt;
  logic [`EBZAT_CNT_W-1:0] waits;
  logic [`EBZAT_ZONE_W-1:0] zone;
  logic is_write;
  ebzat_cfg_s cur;
  logic tick;
  logic rdy;
  logic [`EBZAT_CNT_W-1:0] lead_len;
  logic [`EBZAT_CNT_W-1:0] act_len;
  logic [`EBZAT_CNT_W-1:0] trail_len;

  ebzat_tick u_tick (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .o_tick(tick)
  );

  ebzat_ready u_ready (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_ready(i_ext_ready),
    .i_async_mode(ready_mode[zone]),
    .o_ready(rdy)
  );

  function automatic logic [`EBZAT_CNT_W-1:0] scale(input logic [`EBZAT_CNT_W-1:0] n, input logic dbl);
    scale = dbl ? `EBZAT_CNT_W'(n << 1) : n;
  endfunction

  assign cur = cfg[zone];
  // phase lengths, applied unchecked
  assign lead_len = scale(`EBZAT_CNT_W'(is_write ? cur.wr_lead : cur.rd_lead), cur.double_t);
  assign act_len = scale(`EBZAT_CNT_W'(is_write ? cur.wr_active : cur.rd_active), cur.double_t) +
    `EBZAT_CNT_W'(1);
  assign trail_len = scale(`EBZAT_CNT_W'(is_write ? cur.wr_trail : cur.rd_trail), cur.double_t);

  // per-zone configuration writes
  genvar g;
  generate
    for (g = 0; g < `EBZAT_ZONES; g++) begin : g_zone
      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          cfg[g] <= ebzat_cfg_s'(`EBZAT_CFG_RESET);
        end else if (i_wr && i_addr == `EBZAT_ADDR_W'(g)) begin
          cfg[g] <= ebzat_cfg_s'(i_wdata);
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ready_mode <= '0;
    end else if (i_wr && i_addr == `EBZAT_REG_MODE) begin
      ready_mode <= i_wdata[`EBZAT_ZONES-1:0];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= '0;
    end else if (i_rd) begin
      if (i_addr < `EBZAT_ADDR_W'(`EBZAT_ZONES)) begin
        o_rdata <= cfg[i_addr[`EBZAT_ZONE_W-1:0]];
      end else if (i_addr == `EBZAT_REG_MODE) begin
        o_rdata <= `EBZAT_DATA_W'(ready_mode);
      end else if (i_addr == `EBZAT_REG_STATUS) begin
        o_rdata <= {2'h0, phase, is_write, zone, 3'h0, waits};
      end else begin
        o_rdata <= '0;
      end
    end
  end

  assign o_req_ready = (phase == EBZAT_IDLE);

  // phase sequencer
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      phase <= EBZAT_IDLE;
      cnt <= '0;
      waits <= '0;
      zone <= '0;
      is_write <= 1'b0;
      o_done <= 1'b0;
    end else begin
      o_done <= 1'b0;
      case (phase)
        EBZAT_IDLE: begin
          if (i_req.valid) begin
            zone <= i_req.zone;
            is_write <= i_req.write;
            cnt <= '0;
            waits <= '0;
            phase <= EBZAT_LEAD;
          end
        end
        EBZAT_LEAD: begin
          if (tick) begin
            if (cnt + `EBZAT_CNT_W'(1) >= lead_len) begin
              cnt <= '0;
              phase <= EBZAT_ACTIVE;
            end else begin
              cnt <= cnt + `EBZAT_CNT_W'(1);
            end
          end
        end
        EBZAT_ACTIVE: begin
          if (tick) begin
            if (cnt + `EBZAT_CNT_W'(1) >= act_len) begin
              if (cur.rdy_en && !rdy) begin
                waits <= waits + `EBZAT_CNT_W'(1);
              end else begin
                cnt <= '0;
                phase <= (trail_len == '0) ? EBZAT_IDLE : EBZAT_TRAIL;
                o_done <= (trail_len == '0);
              end
            end else begin
              cnt <= cnt + `EBZAT_CNT_W'(1);
            end
          end
        end
        EBZAT_TRAIL: begin
          if (tick) begin
            if (cnt + `EBZAT_CNT_W'(1) >= trail_len) begin
              cnt <= '0;
              phase <= EBZAT_IDLE;
              o_done <= 1'b1;
            end else begin
              cnt <= cnt + `EBZAT_CNT_W'(1);
            end
          end
        end
        default: begin
          phase <= EBZAT_IDLE;
        end
      endcase
    end
  end

  // strobe outputs from flip-flops
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pins <= '{cs_n: '1, rd_n: 1'b1, we_n: 1'b1, rnw: 1'b1};
    end else begin
      for (int z = 0; z < `EBZAT_ZONES; z++) begin
        o_pins.cs_n[z] <= !(phase != EBZAT_IDLE && zone == `EBZAT_ZONE_W'(z));
      end
      o_pins.rd_n <= !(phase == EBZAT_ACTIVE && !is_write);
      o_pins.we_n <= !(phase == EBZAT_ACTIVE && is_write);
      o_pins.rnw <= !(phase != EBZAT_IDLE && is_write);
    end
  end
endmodule
`default_nettype wire

//--- verilog/ebzat_map.svh
`ifndef EBZAT_MAP_SVH
`define EBZAT_MAP_SVH

`define EBZAT_ZONES 8
`define EBZAT_ZONE_W 3
`define EBZAT_LEAD_W 2
`define EBZAT_ACTIVE_W 3
`define EBZAT_TRAIL_W 2
`define EBZAT_CNT_W 5
`define EBZAT_CFG_W 16
`define EBZAT_ADDR_W 4
`define EBZAT_DATA_W 16
`define EBZAT_TIMING_DIV 1
`define EBZAT_DIV_W 4

// zone_timing_config field positions
`define EBZAT_F_RD_LEAD 0
`define EBZAT_F_RD_ACTIVE 2
`define EBZAT_F_RD_TRAIL 5
`define EBZAT_F_WR_LEAD 7
`define EBZAT_F_WR_ACTIVE 9
`define EBZAT_F_WR_TRAIL 12
`define EBZAT_F_DOUBLE 14
`define EBZAT_F_RDY_EN 15

// register offsets: 0..7 zone configs, 8 ready-mode bits, 9 status
`define EBZAT_REG_MODE 4'h8
`define EBZAT_REG_STATUS 4'h9
`define EBZAT_CFG_RESET 16'h3fff

`endif

//--- verilog/ebzat_pkg.sv
`default_nettype none
package ebzat_pkg;
  `include "ebzat_map.svh"

  typedef enum logic [1:0] {
    EBZAT_IDLE,
    EBZAT_LEAD,
    EBZAT_ACTIVE,
    EBZAT_TRAIL
  } ebzat_phase_e;

  typedef struct packed {
    logic rdy_en;
    logic double_t;
    logic [`EBZAT_TRAIL_W-1:0] wr_trail;
    logic [`EBZAT_ACTIVE_W-1:0] wr_active;
    logic [`EBZAT_LEAD_W-1:0] wr_lead;
    logic [`EBZAT_TRAIL_W-1:0] rd_trail;
    logic [`EBZAT_ACTIVE_W-1:0] rd_active;
    logic [`EBZAT_LEAD_W-1:0] rd_lead;
  } ebzat_cfg_s;

  typedef struct packed {
    logic valid;
    logic write;
    logic [`EBZAT_ZONE_W-1:0] zone;
  } ebzat_req_s;

  typedef struct packed {
    logic [`EBZAT_ZONES-1:0] cs_n;
    logic rd_n;
    logic we_n;
    logic rnw;
  } ebzat_pins_s;
endpackage
`default_nettype wire

//--- verilog/ebzat_ready.sv
`timescale 1ns/100ps
`default_nettype none
module ebzat_ready (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ready,
  input wire logic i_async_mode,
  output logic o_ready
);
  logic sync1;
  logic sync2;
  logic reg1;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      reg1 <= 1'b0;
    end else begin
      sync1 <= i_ready;
      sync2 <= sync1;
      reg1 <= i_ready;
    end
  end

  // two-stage path for asynchronous, one register for synchronous
  assign o_ready = i_async_mode ? sync2 : reg1;
endmodule
`default_nettype wire

//--- verilog/ebzat_tick.sv
`timescale 1ns/100ps
`default_nettype none
`include "ebzat_map.svh"
module ebzat_tick (
  input wire logic i_clk,
  input wire logic i_rst_n,
  output logic o_tick
);
  logic [`EBZAT_DIV_W-1:0] cnt;

  // interface timing clock as enable pulse
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt <= '0;
    end else if (cnt == `EBZAT_DIV_W'(`EBZAT_TIMING_DIV - 1)) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + 1'b1;
    end
  end

  assign o_tick = (cnt == `EBZAT_DIV_W'(`EBZAT_TIMING_DIV - 1));
endmodule
`default_nettype wire
